// file: verif/fawp_host_model.sv
// Host controller model: issues status register three writes and program/erase targets.
// Assumes one bench process calls its tasks, in step with clk.
`timescale 1ns/10ps
`default_nettype none
module fawp_host_model
  import fawp_pkg::*;
(
  input  wire logic              clk,
  output logic                   srWrite,
  output logic [7:0]             srWdata,
  output logic                   cmdValid,
  output logic [ADDR_W-1:0]      cmdStart,
  output logic [ADDR_W-1:0]      cmdLast
);
  initial begin
    srWrite = 1'b0;
    srWdata = 8'h00;
    cmdValid = 1'b0;
    cmdStart = '0;
    cmdLast = '0;
  end
  // Released data lines show the inverse so stale values never pass for fresh ones.
  task automatic writeReg(logic [7:0] d, logic raw);
    @(posedge clk);
    #1;
    srWrite = 1'b1;
    srWdata = raw ? d : (d & SR3_WR_MASK);
    @(posedge clk);
    #1;
    srWrite = 1'b0;
    srWdata = ~srWdata;
  endtask : writeReg
  task automatic sendCmd(logic [ADDR_W-1:0] a, logic [ADDR_W-1:0] b);
    @(posedge clk);
    #1;
    cmdValid = 1'b1;
    cmdStart = a;
    cmdLast = b;
    @(posedge clk);
    #1;
    cmdValid = 1'b0;
    cmdStart = ~a;
    cmdLast = ~b;
  endtask : sendCmd
endmodule : fawp_host_model
`default_nettype wire

// file: verif/fawp_write_protect_test.sv
// Bench for the array write protect block: register, pin select, range and lock checks.
// Assumes the host model drives register writes and command targets.
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin miscompares++; $display("ERROR %s exp %h got %h", n, e, g); end end
module fawp_write_protect_test
  import fawp_pkg::*;
;
  logic clk = 1'b0, srst = 1'b1, quadIoEnable = 1'b0, sharedPinN = 1'b1;
  logic lockWrite = 1'b0, lockValue = 1'b0, sch = 1'b0;
  logic [BLOCK_IDX_W-1:0] lockBlock = '0;
  fawp_range_cfg_t rangeCfg = '0;
  logic srWrite, cmdValid, respValid, respAllowed, pauseActive, hwResetActive, upperIoEnable;
  logic [7:0] srWdata, srRdata;
  logic [1:0] driveStrength;
  logic [ADDR_W-1:0] cmdStart, cmdLast;
  logic [NUM_BLOCKS-1:0] lockM = '1;
  int miscompares = 0, check_count = 0, seed;
  always #4 clk = ~clk;
  fawp_host_model host (.clk(clk), .srWrite(srWrite), .srWdata(srWdata), .cmdValid(cmdValid),
    .cmdStart(cmdStart), .cmdLast(cmdLast));
  fawp_write_protect dut (.clk(clk), .srst(srst), .srWrite(srWrite), .srWdata(srWdata), .srRdata(srRdata),
    .rangeCfg(rangeCfg), .quadIoEnable(quadIoEnable), .sharedPinN(sharedPinN), .pauseActive(pauseActive),
    .hwResetActive(hwResetActive), .upperIoEnable(upperIoEnable), .driveStrength(driveStrength),
    .lockWrite(lockWrite), .lockValue(lockValue), .lockBlock(lockBlock), .cmdValid(cmdValid),
    .cmdStart(cmdStart), .cmdLast(cmdLast), .respValid(respValid), .respAllowed(respAllowed));
  // -------------------------------------------------------------
  // Expectation and drivers
  // -------------------------------------------------------------
  function automatic logic expAllowed(fawp_range_cfg_t c, logic [ADDR_W-1:0] a, logic [ADDR_W-1:0] b);
    logic [24:0] sz;
    logic [24:0] lo;
    logic [24:0] hi;
    logic hit = 1'b0;
    if (sch) begin
      for (int k = a[23:16]; k <= b[23:16]; k++) hit |= lockM[k];
      return !hit;
    end
    if (c.protectLevel == 3'h0) sz = 25'h0;
    else if (c.protectLevel == 3'h7) sz = 25'h1000000;
    else if (!c.sectorGranularity) sz = 25'h1 << (c.protectLevel + 17);
    else sz = 25'h1 << (c.protectLevel > 3 ? 15 : c.protectLevel + 11);
    lo = c.topBottomSelect ? 25'h0 : 25'h1000000 - sz;
    hi = lo + sz - 25'h1;
    if (c.complementProtect) hit = (sz == 0) || a < lo || b > hi;
    else hit = (sz != 0) && !(b < lo || a > hi);
    return !hit;
  endfunction : expAllowed
  task automatic checkCmd(logic [ADDR_W-1:0] a, logic [ADDR_W-1:0] b);
    logic e;
    e = expAllowed(rangeCfg, a, b);
    host.sendCmd(a, b);
    `CHK("respValid", 1'b1, respValid)
    `CHK("respAllowed", e, respAllowed)
  endtask : checkCmd
  // Starts are pulled toward the first and last block, where the sector windows live.
  task automatic randCmd();
    logic [ADDR_W-1:0] a;
    logic [24:0] e;
    rangeCfg = 6'($urandom());
    a = ADDR_W'($urandom());
    if ($urandom_range(1, 0) == 1) a[23:16] = {8{a[0]}};
    e = {1'b0, a} + 25'($urandom_range(0, 131071));
    checkCmd(a, e[24] ? 24'hFFFFFF : e[23:0]);
  endtask : randCmd
  task automatic setLock(int b, logic v);
    @(posedge clk);
    #1;
    lockWrite = 1'b1;
    lockBlock = BLOCK_IDX_W'(b);
    lockValue = v;
    lockM[b] = v;
    @(posedge clk);
    #1;
    lockWrite = 1'b0;
  endtask : setLock
  task automatic test_done();
    if (miscompares == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : test_done
  // -------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------
  initial begin
    seed = $urandom(32'hE26CADDD);
    repeat (10) @(posedge clk);
    #1;
    srst = 1'b0;
    `CHK("srRdata", 8'h60, srRdata)
    `CHK("driveStrength", 2'h3, driveStrength)
    host.writeReg(8'hFF, 1'b1);
    `CHK("srRdata", 8'hE4, srRdata)
    for (int d = 0; d < 4; d++) begin
      host.writeReg({1'b0, 2'(d), 5'h00}, 1'b0);
      `CHK("driveStrength", 2'(d), driveStrength)
    end
    for (int q = 0; q < 2; q++) begin
      for (int p = 0; p < 2; p++) begin
        host.writeReg(p ? 8'hE0 : 8'h60, 1'b0);
        quadIoEnable = q[0];
        sharedPinN = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        `CHK("pauseActive", 1'(!q && !p), pauseActive)
        `CHK("hwResetActive", 1'(!q && p), hwResetActive)
        `CHK("upperIoEnable", q[0], upperIoEnable)
        sharedPinN = 1'b1;
      end
    end
    quadIoEnable = 1'b0;
    host.writeReg(8'h04, 1'b0);
    sch = 1'b1;
    checkCmd(24'h000000, 24'h000000);
    repeat (60) setLock($urandom_range(0, 255), 1'($urandom()));
    repeat (150) randCmd();
    host.writeReg(8'h00, 1'b0);
    sch = 1'b0;
    rangeCfg = 6'h01;
    checkCmd(24'hFC0000, 24'hFC0FFF);
    checkCmd(24'hF80000, 24'hFBFFFF);
    rangeCfg = 6'h1C;
    checkCmd(24'h008000, 24'h008000);
    rangeCfg = 6'h11;
    checkCmd(24'hFFE000, 24'hFFEFFF);
    checkCmd(24'hFFE000, 24'hFFF000);
    rangeCfg = 6'h19;
    checkCmd(24'h001000, 24'h001FFF);
    checkCmd(24'h000FFF, 24'h001000);
    rangeCfg = 6'h21;
    checkCmd(24'hFC0000, 24'hFFFFFF);
    repeat (400) randCmd();
    srst = 1'b1;
    @(posedge clk);
    #1;
    srst = 1'b0;
    lockM = '1;
    `CHK("srRdata", 8'h60, srRdata)
    host.writeReg(8'h04, 1'b0);
    sch = 1'b1;
    checkCmd(24'h123456, 24'h123456);
    test_done();
  end
endmodule : fawp_write_protect_test
`default_nettype wire

// file: verilog/fawp_pkg.sv
// Package for the array write protect block: register layout, reset values,
// address geometry and the carrier struct for the range protect fields.
// Assumes a single 125 MHz clock domain and a 24-bit byte address space.
package fawp_pkg;

  // ---------------------------------------------------------------
  // Address geometry
  // ---------------------------------------------------------------
  localparam int          ADDR_W        = 24;
  localparam int          BLOCK_SHIFT   = 16;
  localparam int          NUM_BLOCKS    = 256;
  localparam int          BLOCK_IDX_W   = 8;
  localparam logic [4:0]  BLK_BASE_LOG2 = 5'h11;
  localparam logic [4:0]  SEC_BASE_LOG2 = 5'h0B;
  localparam logic [4:0]  SEC_MAX_LOG2  = 5'h0F;

  // ---------------------------------------------------------------
  // Third status and configuration register
  // ---------------------------------------------------------------
  localparam int          SCHEME_BIT    = 2;
  localparam int          DRIVE_LO_BIT  = 5;
  localparam int          DRIVE_HI_BIT  = 6;
  localparam int          PIN_SEL_BIT   = 7;
  localparam logic [7:0]  SR3_WR_MASK   = 8'hE4;
  localparam logic [7:0]  SR3_RESET     = 8'h60;

  // ---------------------------------------------------------------
  // Levels and encodings
  // ---------------------------------------------------------------
  localparam logic [2:0]  LEVEL_NONE    = 3'h0;
  localparam logic [2:0]  LEVEL_ALL     = 3'h7;
  localparam logic [1:0]  DRIVE_FULL    = 2'h0;
  localparam logic [1:0]  DRIVE_QUARTER = 2'h3;

  typedef struct packed {
    logic       complementProtect;
    logic       sectorGranularity;
    logic       topBottomSelect;
    logic [2:0] protectLevel;
  } fawp_range_cfg_t;

endpackage : fawp_pkg

// file: verilog/fawp_range_decode.sv
// Range decoder: turns the range protect fields into one inclusive address window.
// Purely combinational; the caller registers whatever it derives from it.
`timescale 1ns/10ps
`default_nettype none
module fawp_range_decode
  import fawp_pkg::*;
(
  input  wire fawp_range_cfg_t        cfg,
  output logic                        regionValid,
  output logic [ADDR_W-1:0]           regionLo,
  output logic [ADDR_W-1:0]           regionHi
);

  // ---------------------------------------------------------------
  // Window size and placement
  // ---------------------------------------------------------------
  logic [4:0]        sizeLog2;
  logic [ADDR_W:0]   sizeBytes;
  logic              wholeArray;

  always_comb begin
    wholeArray = (cfg.protectLevel == LEVEL_ALL);
    regionValid = (cfg.protectLevel != LEVEL_NONE);
    if (cfg.sectorGranularity) begin
      // Levels 100 to 110 share the largest sector window; 111 takes the whole array.
      if (cfg.protectLevel[2]) begin
        sizeLog2 = SEC_MAX_LOG2;
      end else begin
        sizeLog2 = SEC_BASE_LOG2 + {2'h0, cfg.protectLevel};
      end
    end else begin
      sizeLog2 = BLK_BASE_LOG2 + {2'h0, cfg.protectLevel};
    end
    sizeBytes = (ADDR_W+1)'(1) << sizeLog2;
    if (wholeArray) begin
      regionLo = '0;
      regionHi = '1;
    end else if (cfg.topBottomSelect) begin
      regionLo = '0;
      regionHi = ADDR_W'(sizeBytes - (ADDR_W+1)'(1));
    end else begin
      regionLo = ADDR_W'(((ADDR_W+1)'(1) << ADDR_W) - sizeBytes);
      regionHi = '1;
    end
  end

endmodule : fawp_range_decode
`default_nettype wire

// file: verilog/fawp_write_protect.sv
// Array write protect block of a serial flash: third status register, range and
// per-block protection check, drive strength and shared pause/reset pin select.
// Assumes the instruction decoder presents register writes and program/erase
// targets as one-cycle strobes synchronous to clk.
//
// How it works
// - Scheme 0 protects by range fields.
// - Scheme 1 protects by per-block lock bits.
// - All lock bits set on reset.
// - Drive field picks 100/75/50/25 percent, default 25.
// - Pin select: 0 pause, 1 reset.
// - Quad enable disables pause and reset.
// - Reserved bits ignore writes.
// - Block levels protect 256KB doubling, 111 all.
// - Sector levels protect 4KB to 32KB, 111 all.
// - Touching protected area blocks program/erase.
// - Complement inverts the protected region.
// - Quad enable frees upper data lines.
`timescale 1ns/10ps
`default_nettype none
module fawp_write_protect
  import fawp_pkg::*;
#(
  parameter int NUM_LOCKS = NUM_BLOCKS
)
(
  input  wire logic                   clk,
  input  wire logic                   srst,
  input  wire logic                   srWrite,
  input  wire logic [7:0]             srWdata,
  output logic      [7:0]             srRdata,
  input  wire fawp_range_cfg_t        rangeCfg,
  input  wire logic                   quadIoEnable,
  input  wire logic                   sharedPinN,
  output logic                        pauseActive,
  output logic                        hwResetActive,
  output logic                        upperIoEnable,
  output logic      [1:0]             driveStrength,
  input  wire logic                   lockWrite,
  input  wire logic                   lockValue,
  input  wire logic [BLOCK_IDX_W-1:0] lockBlock,
  input  wire logic                   cmdValid,
  input  wire logic [ADDR_W-1:0]      cmdStart,
  input  wire logic [ADDR_W-1:0]      cmdLast,
  output logic                        respValid,
  output logic                        respAllowed
);

  if (NUM_LOCKS != NUM_BLOCKS) begin : g_bad_locks
    $error("NUM_LOCKS must equal the number of 64KB blocks");
  end

  // ---------------------------------------------------------------
  // Status register three
  // ---------------------------------------------------------------
  logic [7:0] sr3_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      sr3_q <= SR3_RESET;
    end else if (srWrite) begin
      sr3_q <= srWdata & SR3_WR_MASK;
    end
  end

  assign srRdata       = sr3_q;
  assign driveStrength = {sr3_q[DRIVE_HI_BIT], sr3_q[DRIVE_LO_BIT]};

  // ---------------------------------------------------------------
  // Shared pin function
  // ---------------------------------------------------------------
  logic pause_q;
  logic hwReset_q;
  logic upperIo_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      pause_q   <= 1'b0;
      hwReset_q <= 1'b0;
      upperIo_q <= 1'b0;
    end else begin
      upperIo_q <= quadIoEnable;
      pause_q   <= !quadIoEnable && !sr3_q[PIN_SEL_BIT] && !sharedPinN;
      hwReset_q <= !quadIoEnable && sr3_q[PIN_SEL_BIT] && !sharedPinN;
    end
  end

  assign pauseActive   = pause_q;
  assign hwResetActive = hwReset_q;
  assign upperIoEnable = upperIo_q;

  // ---------------------------------------------------------------
  // Individual block locks
  // ---------------------------------------------------------------
  // One lock bit per 64KB block; finer sector locks are not kept here.
  logic [NUM_LOCKS-1:0] lock_q;

  always_ff @(posedge clk) begin
    if (srst || hwReset_q) begin
      lock_q <= '1;
    end else if (lockWrite) begin
      lock_q[lockBlock] <= lockValue;
    end
  end

  // ---------------------------------------------------------------
  // Protection check
  // ---------------------------------------------------------------
  logic              regionValid;
  logic [ADDR_W-1:0] regionLo;
  logic [ADDR_W-1:0] regionHi;

  fawp_range_decode u_range (
    .cfg         (rangeCfg),
    .regionValid (regionValid),
    .regionLo    (regionLo),
    .regionHi    (regionHi)
  );

  logic touchesRegion;
  logic insideRegion;
  logic rangeHit;
  logic lockHit;

  always_comb begin
    touchesRegion = regionValid && (cmdStart <= regionHi) && (cmdLast >= regionLo);
    insideRegion  = regionValid && (cmdStart >= regionLo) && (cmdLast <= regionHi);
    // With complement set, anything reaching outside the window is protected.
    rangeHit = rangeCfg.complementProtect ? !insideRegion : touchesRegion;
    lockHit = 1'b0;
    for (int b = 0; b < NUM_LOCKS; b++) begin
      if (lock_q[b] && (BLOCK_IDX_W'(b) >= cmdStart[ADDR_W-1:BLOCK_SHIFT]) &&
          (BLOCK_IDX_W'(b) <= cmdLast[ADDR_W-1:BLOCK_SHIFT])) begin
        lockHit = 1'b1;
      end
    end
  end

  logic respValid_q;
  logic respAllowed_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      respValid_q   <= 1'b0;
      respAllowed_q <= 1'b0;
    end else begin
      respValid_q <= cmdValid;
      if (cmdValid) begin
        respAllowed_q <= sr3_q[SCHEME_BIT] ? !lockHit : !rangeHit;
      end
    end
  end

  assign respValid   = respValid_q;
  assign respAllowed = respAllowed_q;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  chk_reset_locks: assert property ($past(srst) |-> &lock_q)
    else $error("Lock bits not all set after reset.");

  chk_drive_write: assert property (srWrite |=> driveStrength == {$past(srWdata[6]), $past(srWdata[5])})
    else $error("Drive strength does not follow the written field.");

  chk_reserved_bits: assert property ((srRdata & ~SR3_WR_MASK) == 8'h00)
    else $error("Reserved register bits took a value.");

  chk_quad_pin_off: assert property (quadIoEnable |=> !pauseActive && !hwResetActive)
    else $error("Pin function active with quad enable set.");

  chk_pin_pause: assert property (!quadIoEnable && !sr3_q[PIN_SEL_BIT] && !sharedPinN && !srWrite
                                  |=> pauseActive && !hwResetActive)
    else $error("Pause not selected by pin select zero.");

  chk_level_all: assert property (cmdValid && !sr3_q[SCHEME_BIT] && !rangeCfg.complementProtect &&
                                  rangeCfg.protectLevel == LEVEL_ALL |=> respValid && !respAllowed)
    else $error("Whole-array level did not block.");

  chk_level_none: assert property (cmdValid && !sr3_q[SCHEME_BIT] && !rangeCfg.complementProtect &&
                                   rangeCfg.protectLevel == LEVEL_NONE |=> respValid && respAllowed)
    else $error("Level zero blocked a command.");

  chk_cmp_none_all: assert property (cmdValid && !sr3_q[SCHEME_BIT] && rangeCfg.complementProtect &&
                                     rangeCfg.protectLevel == LEVEL_NONE |=> !respAllowed)
    else $error("Complement of empty window did not block.");

  chk_scheme_locks: assert property (cmdValid && sr3_q[SCHEME_BIT] && lock_q[cmdStart[ADDR_W-1:BLOCK_SHIFT]]
                                     |=> !respAllowed)
    else $error("Locked block was not blocked.");

  chk_sector_top: assert property (cmdValid && !sr3_q[SCHEME_BIT] && !rangeCfg.complementProtect &&
                                   rangeCfg.sectorGranularity && !rangeCfg.topBottomSelect &&
                                   rangeCfg.protectLevel == 3'h1 && cmdLast == 24'hFFEFFF
                                   |=> respAllowed)
    else $error("Top 4KB window reached below its base.");

  chk_sector_bottom: assert property (cmdValid && !sr3_q[SCHEME_BIT] && !rangeCfg.complementProtect &&
                                      rangeCfg.sectorGranularity && rangeCfg.topBottomSelect &&
                                      rangeCfg.protectLevel == 3'h1 && cmdStart == 24'h001000
                                      |=> respAllowed)
    else $error("Bottom 4KB window reached above its end.");

  chk_resp_follows: assert property (cmdValid |=> respValid)
    else $error("No response one cycle after a command.");

  chk_resp_idle: assert property (!cmdValid |=> !respValid)
    else $error("Response without a command.");

  chk_verdict_hold: assert property (!cmdValid |=> $stable(respAllowed))
    else $error("Verdict changed without a command.");

  chk_pin_relock: assert property (hwResetActive |=> &lock_q)
    else $error("Lock bits not set after pin reset.");

  chk_upper_io: assert property (quadIoEnable |=> upperIoEnable)
    else $error("Upper data lines not enabled by quad enable.");

endmodule : fawp_write_protect
`default_nettype wire
